/* rtl/tau_clk_regs.svh */
/*
  register map, field positions, reset values for the timer unit clock prescaler.
  assumes inclusion by bare name from design files.
*/
`ifndef TAU_CLK_REGS_SVH
`define TAU_CLK_REGS_SVH

// ----------------------------------------
// register word indices: the byte address is four times the index
// ----------------------------------------
`define PER_ENABLE_OFFSET 20'hf00f0
`define PRESCALER_SEL_OFFSET 20'hf01b6
`define CHAN_STOP_OFFSET 20'hf01b0
`define CHAN_STATUS_OFFSET 20'hf01b4

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define GATE_BIT 0
`define PER_ENABLE_MASK 8'ha5
`define PER_ENABLE_RESET 8'h00
`define PRESCALER_SEL_MASK 16'h33ff
`define PRESCALER_SEL_RESET 16'h0000
`define CH0_LSB 0
`define CH1_LSB 4
`define CH2_LSB 8
`define CH3_LSB 12
`define CHAN_STOP_RESET 8'h00
`define COUNTER_INIT 16'hffff

`endif

/* rtl/tau_clk_pkg.sv */
/*
  types shared by the prescaler design files.
  assumes nothing of its surroundings.
*/
package tau_clk_pkg;
  typedef logic [3:0] divider_code_t;
  typedef logic [1:0] short_code_t;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_write = 3'b010,
    st_read = 3'b100
  } bus_state_e;
endpackage : tau_clk_pkg

/* rtl/prescale_counter.sv */
/*
  free-running binary prescale counter with synchronous hold at zero.
  assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module prescale_counter #(
  parameter int WIDTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic [WIDTH-1:0] count
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule : prescale_counter

/* rtl/clock_pulse_select.sv */
/*
  turns a divider exponent into a one-cycle enable pulse from the prescale count.
  assumes the count runs from zero while enabled.
*/
`timescale 1ns/1ns
module clock_pulse_select #(
  parameter int WIDTH = 16
) (
  input wire logic run,
  input wire logic [WIDTH-1:0] count,
  input wire logic [3:0] exponent,
  output logic pulse
);
  logic [WIDTH-1:0] mask;
  always_comb begin
    mask = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (i < int'(exponent)) begin
        mask[i] = 1'b1;
      end
    end
    // pulse when low bits all ones: one cycle every 2^k
    pulse = run && ((count & mask) == mask);
  end
endmodule : clock_pulse_select

/* rtl/timer_unit_clock_prescaler.sv */
/*
  timer unit clock gate, prescaler select register and four shared clock enables,
  with an ahb-lite slave for the registers.
  assumes one hclk domain, single word transfers, and software keeping its own rules.
*/
`timescale 1ns/1ns
`include "tau_clk_regs.svh"
module timer_unit_clock_prescaler
  import tau_clk_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 15,
  parameter int ADDR_WIDTH = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic unit_clock_enable,
  output logic unit_reset_n,
  output logic shared_clock_0,
  output logic shared_clock_1,
  output logic shared_clock_2,
  output logic shared_clock_3,
  output logic [7:0] channel_stop_pulse,
  output logic [15:0] channel_counter_init
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // one-hot select from a word index: enable, prescaler select, stop, status
  function automatic logic [3:0] reg_select(input logic [ADDR_WIDTH-1:0] index);
    if (index == `PER_ENABLE_OFFSET) begin
      reg_select = 4'h1;
    end else if (index == `PRESCALER_SEL_OFFSET) begin
      reg_select = 4'h2;
    end else if (index == `CHAN_STOP_OFFSET) begin
      reg_select = 4'h4;
    end else if (index == `CHAN_STATUS_OFFSET) begin
      reg_select = 4'h8;
    end else begin
      reg_select = 4'h0;
    end
  endfunction : reg_select

  // write starting on byte lane 0 and at least 2^min_size bytes wide
  function automatic logic low_lanes(input logic [2:0] size, input logic [1:0] lane, input logic [2:0] min_size);
    low_lanes = (lane == 2'b00) && (size >= min_size);
  endfunction : low_lanes

  // ----------------------------------------
  // address phase capture
  // ----------------------------------------
  bus_state_e state_reg;
  bus_state_e state_next;
  logic [ADDR_WIDTH-1:0] addr_reg;
  logic [2:0] size_reg;
  logic [1:0] lane_reg;
  logic accept;
  logic [3:0] sel_now;
  logic [3:0] sel_reg;

  assign accept = hsel && hready && htrans[1];
  // word index is the byte address over four; byte lanes play no part in the decode
  assign sel_now = reg_select(haddr[ADDR_WIDTH+1:2]);
  assign sel_reg = reg_select(addr_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (accept) begin
          state_next = hwrite ? st_write : st_read;
        end
      end
      st_write, st_read: begin
        if (accept) begin
          state_next = hwrite ? st_write : st_read;
        end else if (hready) begin
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= '0;
      size_reg <= 3'h0;
      lane_reg <= 2'h0;
    end else if (accept) begin
      addr_reg <= haddr[ADDR_WIDTH+1:2];
      size_reg <= hsize;
      lane_reg <= haddr[1:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic [7:0] per_enable_reg;
  logic [15:0] prescaler_select_reg;
  logic gate;
  logic wr_cycle;
  logic wr_per;
  logic wr_tps;
  logic wr_stop;

  assign gate = per_enable_reg[`GATE_BIT];
  assign wr_cycle = (state_reg == st_write);

  always_comb begin
    wr_per = 1'b0;
    wr_tps = 1'b0;
    wr_stop = 1'b0;
    if (!wr_cycle) begin
      wr_per = 1'b0;
    end else if (sel_reg[0]) begin
      wr_per = low_lanes(size_reg, lane_reg, 3'h0);
    end else if (sel_reg[1]) begin
      // only a full 16-bit or wider write lands here
      wr_tps = gate && low_lanes(size_reg, lane_reg, 3'h1);
    end else if (sel_reg[2]) begin
      wr_stop = gate && low_lanes(size_reg, lane_reg, 3'h0);
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // byte 0 of the word carries the enable register; bit writes are byte writes here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_enable_reg <= `PER_ENABLE_RESET;
    end else if (wr_per) begin
      per_enable_reg <= hwdata[7:0] & `PER_ENABLE_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescaler_select_reg <= `PRESCALER_SEL_RESET;
    end else if (!gate) begin
      prescaler_select_reg <= `PRESCALER_SEL_RESET;
    end else if (wr_tps) begin
      prescaler_select_reg <= hwdata[15:0] & `PRESCALER_SEL_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_stop_pulse <= `CHAN_STOP_RESET;
    end else if (wr_stop) begin
      channel_stop_pulse <= hwdata[7:0];
    end else begin
      channel_stop_pulse <= `CHAN_STOP_RESET;
    end
  end

  // ----------------------------------------
  // gate and unit reset
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_clock_enable <= 1'b0;
    end else begin
      unit_clock_enable <= gate;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_reset_n <= 1'b0;
    end else begin
      unit_reset_n <= gate;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_counter_init <= `COUNTER_INIT;
    end else if (!gate) begin
      channel_counter_init <= `COUNTER_INIT;
    end
  end

  // ----------------------------------------
  // prescaler and shared clocks
  // ----------------------------------------
  logic [PRESCALE_WIDTH-1:0] count;
  divider_code_t exp_reg [4];
  divider_code_t exp_next [4];
  logic [3:0] pulse_next;

  // two-bit codes: low clock gives exponents 1,2,4,6 and high clock 8,10,12,14
  function automatic divider_code_t short_exp(input short_code_t code, input logic high);
    if (!high && (code == 2'b00)) begin
      short_exp = 4'h1;
    end else begin
      short_exp = {high, code, 1'b0};
    end
  endfunction : short_exp

  prescale_counter #(.WIDTH(PRESCALE_WIDTH)) u_count (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(gate),
    .count(count)
  );

  always_comb begin
    exp_next[0] = prescaler_select_reg[`CH0_LSB +: 4];
    exp_next[1] = prescaler_select_reg[`CH1_LSB +: 4];
    exp_next[2] = short_exp(prescaler_select_reg[`CH2_LSB +: 2], 1'b0);
    exp_next[3] = short_exp(prescaler_select_reg[`CH3_LSB +: 2], 1'b1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        exp_reg[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        exp_reg[i] <= exp_next[i];
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_pulse
    clock_pulse_select #(.WIDTH(PRESCALE_WIDTH)) u_sel (
      .run(gate),
      .count(count),
      .exponent(exp_reg[g]),
      .pulse(pulse_next[g])
    );
  end

  // ----------------------------------------
  // shared clock outputs
  // ----------------------------------------
  // pulses registered: high one hclk period each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_clock_0 <= 1'b0;
    end else begin
      shared_clock_0 <= pulse_next[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_clock_1 <= 1'b0;
    end else begin
      shared_clock_1 <= pulse_next[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_clock_2 <= 1'b0;
    end else begin
      shared_clock_2 <= pulse_next[2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_clock_3 <= 1'b0;
    end else begin
      shared_clock_3 <= pulse_next[3];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (!accept || hwrite) begin
      rdata_next = 32'h0000_0000;
    end else if (sel_now[0]) begin
      rdata_next = {24'h000000, per_enable_reg};
    end else if (sel_now[1]) begin
      rdata_next = {16'h0000, prescaler_select_reg};
    end else if (sel_now[2]) begin
      rdata_next = 32'h0000_0000;
    end else if (sel_now[3]) begin
      rdata_next = {28'h0000000, pulse_next};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept) begin
      hrdata <= rdata_next;
    end
  end

endmodule : timer_unit_clock_prescaler

/* test/prescaler_chk.sv */
/* checker of the prescaler port behaviour
   assumes binding to the top module */
`timescale 1ns/1ns
module prescaler_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic unit_clock_enable,
  input wire logic unit_reset_n,
  input wire logic shared_clock_0,
  input wire logic shared_clock_1,
  input wire logic shared_clock_2,
  input wire logic shared_clock_3,
  input wire logic [7:0] channel_stop_pulse,
  input wire logic [15:0] channel_counter_init
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_gate_off_reset: assert property (!unit_clock_enable [*2] |-> !unit_reset_n) else $error("unit runs gated");
  a_gate_on_run: assert property (unit_clock_enable [*2] |-> unit_reset_n) else $error("unit held");
  a_gated_quiet: assert property (!unit_reset_n [*3] |->
    {shared_clock_3, shared_clock_2, shared_clock_1, shared_clock_0} == 4'h0) else $error("pulse while gated");
  a_clk2_width: assert property ($rose(shared_clock_2) |=> !shared_clock_2) else $error("wide pulse");
  a_clk3_gap: assert property ($rose(shared_clock_3) |=> !shared_clock_3 [*8]) else $error("short gap");
  a_preset_ones: assert property (channel_counter_init == 16'hffff) else $error("bad preset");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled");
  a_stop_gated: assert property (channel_stop_pulse != 8'h00 |-> unit_reset_n) else $error("stop gated");
  c_enable: cover property ($rose(unit_reset_n));
  c_clk3: cover property ($rose(shared_clock_3));
  c_stop: cover property (channel_stop_pulse == 8'hff);
endmodule : prescaler_chk

bind timer_unit_clock_prescaler prescaler_chk i_prescaler_chk (.hclk, .hresetn, .hreadyout, .hresp,
  .unit_clock_enable, .unit_reset_n, .shared_clock_0, .shared_clock_1, .shared_clock_2, .shared_clock_3,
  .channel_stop_pulse, .channel_counter_init);

/* test/timer_unit_clock_prescaler_bench.sv */
/* self-checking bench for the timer unit clock prescaler
   assumes design and checker compiled first */
`timescale 1ns/1ns
`include "tau_clk_regs.svh"
module timer_unit_clock_prescaler_bench;
  // ----
  // stimulus and checks
  // ----
  localparam logic [19:0] per_a = `PER_ENABLE_OFFSET;
  localparam logic [19:0] sel_a = `PRESCALER_SEL_OFFSET;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready, hreadyout, hresp, unit_clock_enable, unit_reset_n;
  logic [3:0] sc;
  logic [7:0] channel_stop_pulse;
  logic [15:0] channel_counter_init;
  int n_mismatch = 0;
  int n_compared = 0;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  timer_unit_clock_prescaler i_timer_unit_clock_prescaler (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .unit_clock_enable, .unit_reset_n,
    .shared_clock_0(sc[0]), .shared_clock_1(sc[1]), .shared_clock_2(sc[2]), .shared_clock_3(sc[3]),
    .channel_stop_pulse, .channel_counter_init);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [19:0] a, input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {10'h000, a, 2'b00};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rchk(input string what, input logic [19:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, 3'h2);
    chk(what, exp, rd);
  endtask : rchk
  task automatic stop_chk(input logic [7:0] d, input logic [7:0] exp);
    ahb(1'b1, `CHAN_STOP_OFFSET, {24'h0, d}, 3'h2);
    @(negedge hclk);
    chk("stop pulse", {24'h0, exp}, {24'h0, channel_stop_pulse});
    @(posedge hclk);
  endtask : stop_chk
  task automatic period(input int k, input int p);
    int n;
    n = 0;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
    while (sc[k] !== 1'b1) @(negedge hclk);
    do begin
      @(negedge hclk);
      n++;
    end while (sc[k] !== 1'b1);
    chk("period", p, n);
    @(posedge hclk);
  endtask : period
  task automatic t_reset();
    rchk("enable", per_a, 32'h0);
    rchk("select", sel_a, 32'h0);
    chk("unit reset", 32'h0, {31'h0, unit_reset_n});
    chk("unit clock", 32'h0, {31'h0, unit_clock_enable});
    $display("reset test done");
  endtask : t_reset
  task automatic t_gated();
    ahb(1'b1, sel_a, 32'h12, 3'h2);
    rchk("gated select", sel_a, 32'h0);
    rchk("unmapped", 20'hf0000, 32'h0);
    stop_chk(8'hff, 8'h00);
    chk("preset", 32'hffff, {16'h0, channel_counter_init});
    $display("gated test done");
  endtask : t_gated
  task automatic t_enable();
    ahb(1'b1, per_a, 32'h1, 3'h0);
    rchk("enable", per_a, 32'h1);
    chk("unit clock", 32'h1, {31'h0, unit_clock_enable});
    chk("unit reset", 32'h1, {31'h0, unit_reset_n});
    ahb(1'b1, sel_a, 32'h2210, 3'h2);
    ahb(1'b1, sel_a, 32'h0, 3'h0);
    rchk("select", sel_a, 32'h2210);
    ahb(1'b0, `CHAN_STATUS_OFFSET, 32'h0, 3'h2);
    chk("status", 32'h1, {31'h0, rd[0]});
    stop_chk(8'hff, 8'hff);
    $display("enable test done");
  endtask : t_enable
  task automatic t_divide();
    period(0, 1);
    period(1, 2);
    period(2, 16);
    period(3, 4096);
    ahb(1'b1, sel_a, 32'h01f3, 3'h2);
    period(0, 8);
    period(1, 32768);
    period(2, 4);
    period(3, 256);
    $display("divide test done");
  endtask : t_divide
  task automatic t_gate_off();
    ahb(1'b1, per_a, 32'h0, 3'h2);
    repeat (4) @(posedge hclk);
    chk("shared clocks", 32'h0, {28'h0, sc});
    chk("unit reset", 32'h0, {31'h0, unit_reset_n});
    chk("unit clock", 32'h0, {31'h0, unit_clock_enable});
    rchk("select", sel_a, 32'h0);
    $display("gate off test done");
  endtask : t_gate_off
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #9000000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_gated();
    t_enable();
    t_divide();
    t_gate_off();
    stop_test();
  end
endmodule : timer_unit_clock_prescaler_bench
